// *** tb/cfx_flag_exec_bench.sv ***
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", n, e, a); end end
module cfx_flag_exec_bench;
  import cfx_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic exec_valid = 1'b0;
  cfx_op_t exec_op = OP_NOP;
  logic [3:0] exec_imm = 4'h0;
  logic [3:0] exec_operand = 4'h0;
  logic [10:0] exec_pc = 11'h000;
  logic [10:0] exec_target = 11'h000;
  logic [3:0] event_set = 4'h0;
  logic [3:0] port_change_pin = 4'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] pf, ef, pe, ie, he, se, ps, dm, acc, mwd;
  logic cy, zr, mwr, pcl, d0c, d1c, wdc, hrq, srq, irq;
  logic [10:0] pcv;
  logic [7:0] rdata;
  int err_count = 0;
  int samples_checked = 0;

  cfx_flag_exec DUT (
    .MCLK(mclk), .SRST(srst), .EXEC_VALID(exec_valid), .EXEC_OP(exec_op),
    .EXEC_IMM(exec_imm), .EXEC_OPERAND(exec_operand), .EXEC_PC(exec_pc),
    .EXEC_TARGET(exec_target), .EVENT_SET(event_set), .PORT_CHANGE_PIN(port_change_pin),
    .PARAMETER_FLAGS(pf), .EVENT_FLAGS(ef), .PORT_ENABLE_FLAGS(pe),
    .INTERRUPT_ENABLE_FLAGS(ie), .HOLD_RELEASE_ENABLE_FLAGS(he),
    .STOP_WAKEUP_ENABLE_FLAGS(se), .PORT_STATUS_WORD(ps), .DISPLAY_MODE_SELECT(dm),
    .CARRY_BIT(cy), .ZERO_BIT(zr), .ACCUMULATOR(acc), .MEM_WR(mwr), .MEM_WDATA(mwd),
    .PC_LOAD(pcl), .PC_VALUE(pcv), .DIV_ZERO_CLR(d0c), .DIV_ONE_CLR(d1c),
    .WATCHDOG_CLR(wdc), .HOLD_REQ(hrq), .STOP_REQ(srq), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .IRQ(irq)
  );

  always #50 mclk = ~mclk;

  task automatic final_report;
    $display("Errors %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Issue one instruction; returns in the cycle its effects show, except the PC load of OP_RETURN, which shows one cycle later
  task automatic exec(input cfx_op_t op, input logic [3:0] imm, input logic [3:0] opnd);
    @(posedge mclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_imm <= imm;
    exec_operand <= opnd;
    @(posedge mclk);
    exec_valid <= 1'b0;
    #1;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic t_param;
    exec(OP_SET_PARAM, 4'hF, 4'h0);
    `CHK("param set", 4'h8, pf)
    exec(OP_CLR_PARAM, 4'h7, 4'h0);
    `CHK("param keep", 4'h8, pf)
    exec(OP_CLR_PARAM, 4'h8, 4'h0);
    `CHK("param clear", 4'h0, pf)
  endtask

  task automatic t_event;
    @(posedge mclk);
    event_set <= 4'hF;
    @(posedge mclk);
    event_set <= 4'h0;
    exec(OP_CLR_EVENT, 4'h5, 4'h0);
    `CHK("event clear", 4'hA, ef)
  endtask

  task automatic t_moves;
    logic [3:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 4'h5 : 4'hA;
      exec(OP_MOV_PORT_EN, v, 4'h0);
      exec(OP_MOV_INT_EN, v, 4'h0);
      exec(OP_MOV_HOLD_EN, v, 4'h0);
      exec(OP_MOV_STOP_EN, v, 4'h0);
      exec(OP_MOV_DISPLAY_MODE, v, 4'h0);
      `CHK("port en", v, pe)
      `CHK("int en", v, ie)
      `CHK("hold en", v, he)
      `CHK("stop en", v, se)
      `CHK("display mode", v, dm)
    end
  endtask

  task automatic t_port_status;
    int n;
    @(posedge mclk);
    port_change_pin <= 4'h6;
    n = 0;
    while (ps !== 4'h6 && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 10) begin
      err_count++;
      final_report();
    end
    @(posedge mclk);
    port_change_pin <= 4'h0;
    repeat (4) @(posedge mclk);
    exec(OP_READ_PORT_STATUS, 4'h0, 4'h0);
    `CHK("status acc", 4'h6, acc)
    `CHK("status mem", 4'h6, mwd)
    `CHK("status wr", 1'b1, mwr)
    `CHK("status zero", 1'b0, zr)
    exec(OP_CLR_PORT_STATUS, 4'h0, 4'h0);
    `CHK("status clear", 4'h0, ps)
  endtask

  task automatic t_shift;
    cfx_op_t ops [4] = '{OP_ROTATE_RIGHT, OP_SHIFT_RIGHT, OP_SHIFT_LEFT, OP_ROTATE_LEFT};
    logic [3:0] opnd [4] = '{4'h9, 4'h9, 4'h8, 4'h5};
    logic [3:0] res [4] = '{4'hC, 4'h4, 4'h0, 4'hB};
    logic [3:0] cout = 4'h7;
    exec(OP_SET_CARRY, 4'h0, 4'h0);
    `CHK("carry set", 1'b1, cy)
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        exec(OP_CLR_CARRY, 4'h0, 4'h0);
        `CHK("carry clear", 1'b0, cy)
      end
      exec(ops[i], 4'h0, opnd[i]);
      `CHK("shift acc", res[i], acc)
      `CHK("shift mem", res[i], mwd)
      `CHK("shift wr", 1'b1, mwr)
      `CHK("shift carry", cout[i], cy)
      `CHK("shift zero", res[i] == 4'h0, zr)
    end
  endtask

  task automatic t_pulses;
    exec(OP_CLR_DIV_ZERO, 4'h0, 4'h0);
    `CHK("div0 clr", 1'b1, d0c)
    `CHK("div1 idle", 1'b0, d1c)
    exec(OP_CLR_DIV_ONE, 4'h0, 4'h0);
    `CHK("div1 clr", 1'b1, d1c)
    `CHK("div0 idle", 1'b0, d0c)
    exec(OP_CLR_WATCHDOG, 4'h0, 4'h0);
    `CHK("wdt clr", 1'b1, wdc)
  endtask

  task automatic t_call_return;
    logic [7:0] d;
    exec(OP_RETURN, 4'h0, 4'h0);
    @(posedge mclk);
    #1;
    `CHK("empty return", 1'b0, pcl)
    reg_read(ADDR_IRQ_STATUS, d);
    `CHK("underflow", 1'b1, d[IRQ_UNDERFLOW])
    reg_write(ADDR_IRQ_STATUS, 8'h08);
    exec_pc <= 11'h3FF;
    exec_target <= 11'h7FF;
    exec(OP_CALL, 4'h0, 4'h0);
    `CHK("call load", 1'b1, pcl)
    `CHK("call target", 11'h7FF, pcv)
    exec(OP_RETURN, 4'h0, 4'h0);
    @(posedge mclk);
    #1;
    `CHK("return load", 1'b1, pcl)
    `CHK("return pc", 11'h400, pcv)
    for (int i = 0; i < 9; i++) begin
      exec(OP_CALL, 4'h0, 4'h0);
    end
    reg_read(ADDR_IRQ_STATUS, d);
    `CHK("overflow", 4'h4, d[3:0])
    reg_write(ADDR_IRQ_STATUS, 8'h04);
  endtask

  task automatic t_power_irq;
    logic [7:0] d;
    reg_write(ADDR_IRQ_MASK, 8'h01);
    exec(OP_HOLD, 4'h0, 4'h0);
    `CHK("hold req", 1'b1, hrq)
    exec(OP_STOP, 4'h0, 4'h0);
    `CHK("stop req", 1'b1, srq)
    reg_read(ADDR_IRQ_STATUS, d);
    `CHK("irq status", 4'h3, d[3:0])
    `CHK("irq on", 1'b1, irq)
    reg_write(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("irq masked", 1'b0, irq)
    reg_write(ADDR_IRQ_STATUS, 8'h02);
    reg_write(ADDR_CORE_STATE, 8'hFF);
    reg_read(ADDR_CORE_STATE, d);
    `CHK("core state", 8'h0B, d)
    reg_read(ADDR_IRQ_STATUS, d);
    `CHK("irq clear", 4'h0, d[3:0])
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    t_param();
    t_event();
    t_moves();
    t_port_status();
    t_shift();
    t_pulses();
    t_call_return();
    t_power_irq();
    final_report();
  end
endmodule

// *** verilog/cfx_flag_exec.sv ***
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module cfx_flag_exec
  import cfx_pkg::*;
#(
  parameter bit HAS_DIV_ONE = 1'b1
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Decoded instruction
  input wire logic EXEC_VALID,
  input wire cfx_op_t EXEC_OP,
  input wire logic [NIB_W-1:0] EXEC_IMM,
  input wire logic [NIB_W-1:0] EXEC_OPERAND,
  input wire logic [PC_W-1:0] EXEC_PC,
  input wire logic [PC_W-1:0] EXEC_TARGET,
  // Event sources
  input wire logic [NIB_W-1:0] EVENT_SET,
  input wire logic [NIB_W-1:0] PORT_CHANGE_PIN,
  // Flag state
  output logic [NIB_W-1:0] PARAMETER_FLAGS,
  output logic [NIB_W-1:0] EVENT_FLAGS,
  output logic [NIB_W-1:0] PORT_ENABLE_FLAGS,
  output logic [NIB_W-1:0] INTERRUPT_ENABLE_FLAGS,
  output logic [NIB_W-1:0] HOLD_RELEASE_ENABLE_FLAGS,
  output logic [NIB_W-1:0] STOP_WAKEUP_ENABLE_FLAGS,
  output logic [NIB_W-1:0] PORT_STATUS_WORD,
  output logic [NIB_W-1:0] DISPLAY_MODE_SELECT,
  output logic CARRY_BIT,
  output logic ZERO_BIT,
  output logic [NIB_W-1:0] ACCUMULATOR,
  // Memory write back
  output logic MEM_WR,
  output logic [NIB_W-1:0] MEM_WDATA,
  // Program counter and peripherals
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_VALUE,
  output logic DIV_ZERO_CLR,
  output logic DIV_ONE_CLR,
  output logic WATCHDOG_CLR,
  output logic HOLD_REQ,
  output logic STOP_REQ,
  // Register port
  input wire logic [REG_AW-1:0] REG_ADDR,
  input wire logic [REG_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [REG_DW-1:0] REG_RDATA,
  output logic IRQ
);
  logic [NIB_W-1:0] pin_meta_r, pin_sync_r;
  logic [NIB_W-1:0] param_r, param_nxt, event_r, event_nxt;
  logic [NIB_W-1:0] port_en_r, port_en_nxt, int_en_r, int_en_nxt;
  logic [NIB_W-1:0] hold_en_r, hold_en_nxt, stop_en_r, stop_en_nxt;
  logic [NIB_W-1:0] pstat_r, pstat_nxt, disp_r, disp_nxt;
  logic [NIB_W-1:0] acc_r, acc_nxt, wdata_r, wdata_nxt;
  logic carry_r, carry_nxt, zero_r, zero_nxt, mem_wr_r, mem_wr_nxt;
  logic pc_load_r, pc_load_nxt;
  logic [PC_W-1:0] pc_val_r, pc_val_nxt;
  logic div0_r, div0_nxt, div1_r, div1_nxt, wdog_r, wdog_nxt;
  logic hold_r, hold_nxt, stop_r, stop_nxt;
  logic [NIB_W-1:0] irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt;
  logic [REG_DW-1:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic push, pop, stk_valid, stk_empty, stk_full;
  logic [PC_W-1:0] stk_data;
  logic [NIB_W-1:0] res, irq_ev;
  logic res_carry, res_write;
  cfx_ret_stack #(.W(PC_W), .DEPTH(STACK_DEPTH), .AW($clog2(STACK_DEPTH))) u_stack (
    .clk(MCLK),
    .srst(SRST),
    .push(push),
    .pop(pop),
    .wdata(PC_W'(EXEC_PC + 1'b1)),
    .rdata(stk_data),
    .rvalid(stk_valid),
    .empty(stk_empty),
    .full(stk_full)
  );
  // Pin synchroniser
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pin_meta_r <= NIB_RESET;
      pin_sync_r <= NIB_RESET;
    end else begin
      pin_meta_r <= PORT_CHANGE_PIN;
      pin_sync_r <= pin_meta_r;
    end
  end
  // Instruction execution
  always_comb begin
    param_nxt = param_r;
    event_nxt = event_r;
    port_en_nxt = port_en_r;
    int_en_nxt = int_en_r;
    hold_en_nxt = hold_en_r;
    stop_en_nxt = stop_en_r;
    pstat_nxt = pstat_r;
    disp_nxt = disp_r;
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    res = EXEC_OPERAND;
    res_carry = carry_r;
    res_write = 1'b0;
    pc_load_nxt = stk_valid;
    pc_val_nxt = stk_valid ? stk_data : pc_val_r;
    div0_nxt = 1'b0;
    div1_nxt = 1'b0;
    wdog_nxt = 1'b0;
    hold_nxt = 1'b0;
    stop_nxt = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    irq_ev = '0;
    if (EXEC_VALID) begin
      case (EXEC_OP)
        OP_CLR_PARAM: param_nxt = param_r & ~EXEC_IMM;
        OP_SET_PARAM: param_nxt = param_r | EXEC_IMM;
        OP_CLR_EVENT: event_nxt = event_r & ~EXEC_IMM;
        OP_MOV_PORT_EN: port_en_nxt = EXEC_IMM;
        OP_MOV_INT_EN: int_en_nxt = EXEC_IMM;
        OP_MOV_HOLD_EN: hold_en_nxt = EXEC_IMM;
        OP_MOV_STOP_EN: stop_en_nxt = EXEC_IMM;
        OP_READ_PORT_STATUS: begin
          res = pstat_r;
          res_write = 1'b1;
        end
        OP_CLR_PORT_STATUS: pstat_nxt = NIB_RESET;
        OP_SET_CARRY: carry_nxt = 1'b1;
        OP_CLR_CARRY: carry_nxt = 1'b0;
        OP_CLR_DIV_ZERO: div0_nxt = 1'b1;
        OP_CLR_DIV_ONE: div1_nxt = HAS_DIV_ONE;
        OP_CLR_WATCHDOG: wdog_nxt = 1'b1;
        OP_SHIFT_RIGHT, OP_ROTATE_RIGHT: begin
          res = {(EXEC_OP == OP_ROTATE_RIGHT) & carry_r, EXEC_OPERAND[3:1]};
          res_carry = EXEC_OPERAND[0];
          res_write = 1'b1;
        end
        OP_SHIFT_LEFT, OP_ROTATE_LEFT: begin
          res = {EXEC_OPERAND[2:0], (EXEC_OP == OP_ROTATE_LEFT) & carry_r};
          res_carry = EXEC_OPERAND[3];
          res_write = 1'b1;
        end
        OP_MOV_DISPLAY_MODE: disp_nxt = EXEC_IMM;
        OP_CALL: begin
          push = 1'b1;
          pc_load_nxt = 1'b1;
          pc_val_nxt = EXEC_TARGET;
          irq_ev[IRQ_OVERFLOW] = stk_full;
        end
        OP_RETURN: begin
          pop = 1'b1;
          irq_ev[IRQ_UNDERFLOW] = stk_empty;
        end
        OP_HOLD: begin
          hold_nxt = 1'b1;
          irq_ev[IRQ_HOLD] = 1'b1;
        end
        OP_STOP: begin
          stop_nxt = 1'b1;
          irq_ev[IRQ_STOP] = 1'b1;
        end
        default: ;
      endcase
    end
    param_nxt = param_nxt & PARAM_LIVE_MASK;
    event_nxt = event_nxt | EVENT_SET;
    pstat_nxt = pstat_nxt | pin_sync_r;
    if (res_write) begin
      acc_nxt = res;
      zero_nxt = (res == NIB_RESET);
      if (EXEC_OP != OP_READ_PORT_STATUS) begin
        carry_nxt = res_carry;
      end
    end
    mem_wr_nxt = res_write;
    wdata_nxt = res_write ? res : wdata_r;
  end
  // Register port and interrupt
  always_comb begin
    irq_st_nxt = irq_st_r;
    irq_mask_nxt = irq_mask_r;
    rdata_nxt = '0;
    if (REG_WR && REG_ADDR == ADDR_IRQ_STATUS) begin
      irq_st_nxt = irq_st_r & ~REG_WDATA[NIB_W-1:0];
    end
    if (REG_WR && REG_ADDR == ADDR_IRQ_MASK) begin
      irq_mask_nxt = REG_WDATA[NIB_W-1:0];
    end
    irq_st_nxt = irq_st_nxt | irq_ev;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_IRQ_STATUS: rdata_nxt = {4'h0, irq_st_r};
        ADDR_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
        ADDR_CORE_STATE: rdata_nxt = {2'h0, zero_r, carry_r, acc_r};
        ADDR_FLAG_STATE: rdata_nxt = {pstat_r, event_r};
        default: rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(irq_st_nxt & irq_mask_nxt);
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      param_r <= NIB_RESET;
      event_r <= NIB_RESET;
      port_en_r <= NIB_RESET;
      int_en_r <= NIB_RESET;
      hold_en_r <= NIB_RESET;
      stop_en_r <= NIB_RESET;
      pstat_r <= NIB_RESET;
      disp_r <= NIB_RESET;
      acc_r <= NIB_RESET;
      wdata_r <= NIB_RESET;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      mem_wr_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_val_r <= PC_RESET;
      div0_r <= 1'b0;
      div1_r <= 1'b0;
      wdog_r <= 1'b0;
      hold_r <= 1'b0;
      stop_r <= 1'b0;
      irq_st_r <= IRQ_RESET;
      irq_mask_r <= IRQ_RESET;
      rdata_r <= '0;
      irq_r <= 1'b0;
    end else begin
      param_r <= param_nxt;
      event_r <= event_nxt;
      port_en_r <= port_en_nxt;
      int_en_r <= int_en_nxt;
      hold_en_r <= hold_en_nxt;
      stop_en_r <= stop_en_nxt;
      pstat_r <= pstat_nxt;
      disp_r <= disp_nxt;
      acc_r <= acc_nxt;
      wdata_r <= wdata_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      mem_wr_r <= mem_wr_nxt;
      pc_load_r <= pc_load_nxt;
      pc_val_r <= pc_val_nxt;
      div0_r <= div0_nxt;
      div1_r <= div1_nxt;
      wdog_r <= wdog_nxt;
      hold_r <= hold_nxt;
      stop_r <= stop_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign PARAMETER_FLAGS = param_r;
  assign EVENT_FLAGS = event_r;
  assign PORT_ENABLE_FLAGS = port_en_r;
  assign INTERRUPT_ENABLE_FLAGS = int_en_r;
  assign HOLD_RELEASE_ENABLE_FLAGS = hold_en_r;
  assign STOP_WAKEUP_ENABLE_FLAGS = stop_en_r;
  assign PORT_STATUS_WORD = pstat_r;
  assign DISPLAY_MODE_SELECT = disp_r;
  assign CARRY_BIT = carry_r;
  assign ZERO_BIT = zero_r;
  assign ACCUMULATOR = acc_r;
  assign MEM_WR = mem_wr_r;
  assign MEM_WDATA = wdata_r;
  assign PC_LOAD = pc_load_r;
  assign PC_VALUE = pc_val_r;
  assign DIV_ZERO_CLR = div0_r;
  assign DIV_ONE_CLR = div1_r;
  assign WATCHDOG_CLR = wdog_r;
  assign HOLD_REQ = hold_r;
  assign STOP_REQ = stop_r;
  assign REG_RDATA = rdata_r;
  assign IRQ = irq_r;
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  sequence s_exec(cfx_op_t op);
    EXEC_VALID && EXEC_OP == op;
  endsequence
  property p_clr_param;
    s_exec(OP_CLR_PARAM) |=> (PARAMETER_FLAGS & $past(EXEC_IMM)) == 4'h0;
  endproperty
  a_clr_param: assert property (p_clr_param) else $error("parameter clear failed");
  property p_set_param;
    s_exec(OP_SET_PARAM) |=> PARAMETER_FLAGS[3] == ($past(EXEC_IMM[3]) | $past(param_r[3]));
  endproperty
  a_set_param: assert property (p_set_param) else $error("parameter set failed");
  property p_param_reserved;
    PARAMETER_FLAGS[2:0] == 3'h0;
  endproperty
  a_param_reserved: assert property (p_param_reserved) else $error("reserved bit set");
  property p_clr_event;
    s_exec(OP_CLR_EVENT) |=> (EVENT_FLAGS & $past(EXEC_IMM) & ~$past(EVENT_SET)) == 4'h0;
  endproperty
  a_clr_event: assert property (p_clr_event) else $error("event clear failed");
  property p_mov_enable;
    s_exec(OP_MOV_STOP_EN) |=> STOP_WAKEUP_ENABLE_FLAGS == $past(EXEC_IMM);
  endproperty
  a_mov_enable: assert property (p_mov_enable) else $error("enable load failed");
  property p_read_status;
    s_exec(OP_READ_PORT_STATUS) |=> MEM_WR && ACCUMULATOR == $past(pstat_r)
      && MEM_WDATA == ACCUMULATOR && ZERO_BIT == (ACCUMULATOR == 4'h0);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read failed");
  property p_clr_status;
    s_exec(OP_CLR_PORT_STATUS) |=> PORT_STATUS_WORD == $past(pin_sync_r);
  endproperty
  a_clr_status: assert property (p_clr_status) else $error("status clear failed");
  property p_div_one;
    s_exec(OP_CLR_DIV_ONE) |=> DIV_ONE_CLR == HAS_DIV_ONE
      ##1 (!DIV_ONE_CLR || ($past(EXEC_VALID) && $past(EXEC_OP) == OP_CLR_DIV_ONE));
  endproperty
  a_div_one: assert property (p_div_one) else $error("divider one clear wrong");
  property p_call;
    s_exec(OP_CALL) |=> PC_LOAD && PC_VALUE == $past(EXEC_TARGET);
  endproperty
  a_call: assert property (p_call) else $error("call target not loaded");
  property p_shift_right;
    s_exec(OP_SHIFT_RIGHT) |=> ACCUMULATOR == {1'b0, $past(EXEC_OPERAND[3:1])}
      && CARRY_BIT == $past(EXEC_OPERAND[0]);
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("shift right wrong");
  sequence s_call_ret;
    EXEC_VALID && EXEC_OP == OP_CALL && !stk_full ##1 !EXEC_VALID ##1 s_exec(OP_RETURN);
  endsequence
  property p_return;
    s_call_ret |-> ##2 PC_LOAD && PC_VALUE == $past(EXEC_PC, 4) + 11'h001;
  endproperty
  a_return: assert property (p_return) else $error("return address wrong");
  property p_irq;
    IRQ == |(irq_st_r & irq_mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule

// *** verilog/cfx_pkg.sv ***
// How it works
// - Clear parameter flags where immediate bit is one
// - Set parameter flags where immediate bit is one
// - Parameter flag bits zero to two reserved
// - Clear event flags selected by immediate, one cycle
// - Load port enable flags from immediate
// - Load interrupt enable flags from immediate
// - Load hold release enable flags from immediate
// - Load stop wake-up enable flags from immediate
// - Port status read goes to accumulator, memory, zero
// - One instruction clears port status word
// - Divider zero clear resets low four bits only
// - Divider one clear only on second-divider variant
// - Load display mode select from immediate
// - Call pushes next address, loads eleven-bit target
package cfx_pkg;
  localparam int NIB_W = 4;
  localparam int PC_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int OP_W = 5;
  localparam int REG_AW = 2;
  localparam int REG_DW = 8;
  localparam logic [NIB_W-1:0] PARAM_LIVE_MASK = 4'h8;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [REG_AW-1:0] ADDR_IRQ_STATUS = 2'h0;
  localparam logic [REG_AW-1:0] ADDR_IRQ_MASK = 2'h1;
  localparam logic [REG_AW-1:0] ADDR_CORE_STATE = 2'h2;
  localparam logic [REG_AW-1:0] ADDR_FLAG_STATE = 2'h3;
  localparam int IRQ_HOLD = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam int IRQ_UNDERFLOW = 3;
  localparam logic [NIB_W-1:0] IRQ_RESET = 4'h0;

  typedef enum logic [OP_W-1:0] {
    OP_NOP = 5'h00,
    OP_CLR_PARAM = 5'h01,
    OP_SET_PARAM = 5'h02,
    OP_CLR_EVENT = 5'h03,
    OP_MOV_PORT_EN = 5'h04,
    OP_MOV_INT_EN = 5'h05,
    OP_MOV_HOLD_EN = 5'h06,
    OP_MOV_STOP_EN = 5'h07,
    OP_READ_PORT_STATUS = 5'h08,
    OP_CLR_PORT_STATUS = 5'h09,
    OP_SET_CARRY = 5'h0A,
    OP_CLR_CARRY = 5'h0B,
    OP_CLR_DIV_ZERO = 5'h0C,
    OP_CLR_DIV_ONE = 5'h0D,
    OP_CLR_WATCHDOG = 5'h0E,
    OP_SHIFT_RIGHT = 5'h0F,
    OP_ROTATE_RIGHT = 5'h10,
    OP_SHIFT_LEFT = 5'h11,
    OP_ROTATE_LEFT = 5'h12,
    OP_MOV_DISPLAY_MODE = 5'h13,
    OP_CALL = 5'h14,
    OP_RETURN = 5'h15,
    OP_HOLD = 5'h16,
    OP_STOP = 5'h17
  } cfx_op_t;
endpackage

// *** verilog/cfx_ret_stack.sv ***
`timescale 1ns/10ps
module cfx_ret_stack #(
  parameter int W = 11,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Requests
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] wdata,
  // Results
  output logic [W-1:0] rdata,
  output logic rvalid,
  output logic empty,
  output logic full
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] count_r, count_nxt;
  logic [W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic do_push, do_pop;

  always_comb begin
    do_push = push && (count_r != DEPTH[AW:0]);
    do_pop = pop && (count_r != '0);
    count_nxt = count_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (do_push) begin
      count_nxt = count_r + 1'b1;
    end else if (do_pop) begin
      count_nxt = count_r - 1'b1;
      rdata_nxt = mem[count_nxt[AW-1:0]];
      rvalid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[count_r[AW-1:0]] <= wdata;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign empty = (count_r == '0);
  assign full = (count_r == DEPTH[AW:0]);
endmodule
